// *** hw/dma_irq_unit.sv ***
// interrupt masking and receive flow-threshold registers, wishbone slave
// Summary of operation
// - write one bit 8+ch enables low-buffer irq
// - write one bit ch enables packet irq
// - write one to clear register disables enables
// - raw bit 1 shows host error flag
// - raw bit 0 shows counter half-full flag
// - masked bits shown only when enabled
// - set bit 1 enables host error irq
// - set bit 0 enables counter irq
// - clear bits 1/0 disable those irqs
// - per-channel 8-bit threshold, resets zero
// - per-channel 16-bit free-buffer count
// - compare threshold against free count
// - write to free count adds value
// - free count wraps modulo 2^16 on overflow
// - each frame subtracts its consumed buffers
// - threshold and count per channel 0-7
// - raw rx: low flags 15:8, packet 7:0
// - half-full when any counter at/above 8000_0000h
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
module dma_irq_unit
   import irq_pkg::*;
#(
   parameter int NUM_CHAN = 8,
   parameter int NUM_STATS = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // receive port events
   input wire logic [NUM_CHAN-1:0] rx_chan_packet_flag,
   input wire logic [NUM_CHAN-1:0] rx_frame_done,
   input wire logic [NUM_CHAN*FREE_W-1:0] rx_frame_bufs,
   // host error and statistics
   input wire logic host_error_flag,
   input wire logic [NUM_STATS*STAT_W-1:0] stat_values,
   // interrupt state out
   output logic [2*NUM_CHAN-1:0] rx_irq_masked,
   output logic [1:0] misc_irq_masked
);
   // elaboration check: map holds eight channels
   if (NUM_CHAN < 1 || NUM_CHAN > 8) begin : g_bad_chan
      $error("NUM_CHAN must be 1 to 8");
   end
   if (NUM_STATS < 1) begin : g_bad_stats
      $error("NUM_STATS must be at least 1");
   end

   typedef struct packed {
      logic [2*NUM_CHAN-1:0] rx_en;
      logic [1:0] misc_en;
      logic [2*NUM_CHAN-1:0] rx_raw;
      logic [2*NUM_CHAN-1:0] rx_masked;
      logic [1:0] misc_raw;
      logic [1:0] misc_masked;
      logic [31:0] dat;
      logic ack;
      logic err;
   } top_s;

   top_s st_r;
   top_s st_nxt;

   logic [NUM_CHAN-1:0] thresh_we;
   logic [NUM_CHAN-1:0] free_we;
   logic [NUM_CHAN-1:0] low_flag;
   logic [THRESH_W-1:0] thresh [NUM_CHAN];
   logic [FREE_W-1:0] free_cnt [NUM_CHAN];
   logic half_full;
   logic req;
   logic wr_ok;

   // a new request: cycle and strobe high, not yet answered
   assign req = wb_cyc_i && wb_stb_i && !st_r.ack && !st_r.err;
   // word writes need all lanes so counters add a whole value
   assign wr_ok = req && wb_we_i && (wb_sel_i == 4'hf);

   // per-channel threshold and free-buffer logic
   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      localparam logic [7:0] THR_ADR = OFS_THRESH_BASE + 8'(4 * c);
      localparam logic [7:0] FRE_ADR = OFS_FREE_BASE + 8'(4 * c);
      assign thresh_we[c] = wr_ok && (wb_adr_i == THR_ADR);
      assign free_we[c] = wr_ok && (wb_adr_i == FRE_ADR);
      rx_chan_flow u_chan (
         .clk(clk),
         .rst(rst),
         .thresh_we(thresh_we[c]),
         .free_we(free_we[c]),
         .wdata(wb_dat_i),
         .frame_done(rx_frame_done[c]),
         .frame_bufs(rx_frame_bufs[c*FREE_W +: FREE_W]),
         .thresh(thresh[c]),
         .free_cnt(free_cnt[c]),
         .low_flag(low_flag[c])
      );
   end

   // statistics half-range detector
   stat_half_detect #(
      .NUM_STATS(NUM_STATS)
   ) u_stat (
      .clk(clk),
      .rst(rst),
      .stat_values(stat_values),
      .half_full(half_full)
   );

   // next state: enables, status pipelines and bus answer
   always_comb begin
      logic [2*NUM_CHAN-1:0] wmask;
      logic [31:0] rd;
      logic hit;
      logic [7:0] idx;
      wmask = wb_dat_i[2*NUM_CHAN-1:0];
      rd = 32'h0000_0000;
      hit = 1'b1;
      idx = 8'h00;
      st_nxt = st_r;
      // set and clear enables by writing ones
      if (wr_ok && wb_adr_i == OFS_RX_EN_SET) begin
         st_nxt.rx_en = st_r.rx_en | wmask;
      end
      if (wr_ok && wb_adr_i == OFS_RX_EN_CLR) begin
         st_nxt.rx_en = st_r.rx_en & ~wmask;
      end
      if (wr_ok && wb_adr_i == OFS_MISC_EN_SET) begin
         st_nxt.misc_en = st_r.misc_en | wb_dat_i[1:0];
      end
      if (wr_ok && wb_adr_i == OFS_MISC_EN_CLR) begin
         st_nxt.misc_en = st_r.misc_en & ~wb_dat_i[1:0];
      end
      // raw status: low flags high half, packet flags low half
      st_nxt.rx_raw = {low_flag, rx_chan_packet_flag};
      st_nxt.misc_raw[HOST_ERR_BIT] = host_error_flag;
      st_nxt.misc_raw[HALF_FULL_BIT] = half_full;
      // masked status is raw gated by enable
      st_nxt.rx_masked = st_nxt.rx_raw & st_nxt.rx_en;
      st_nxt.misc_masked = st_nxt.misc_raw & st_nxt.misc_en;
      // read decode; reserved bits stay zero
      unique case (wb_adr_i)
         OFS_RX_RAW: rd[2*NUM_CHAN-1:0] = st_r.rx_raw;
         OFS_RX_MASKED: rd[2*NUM_CHAN-1:0] = st_r.rx_masked;
         OFS_RX_EN_SET, OFS_RX_EN_CLR: rd[2*NUM_CHAN-1:0] = st_r.rx_en;
         OFS_MISC_RAW: rd[1:0] = st_r.misc_raw;
         OFS_MISC_MASKED: rd[1:0] = st_r.misc_masked;
         OFS_MISC_EN_SET, OFS_MISC_EN_CLR: rd[1:0] = st_r.misc_en;
         default: begin
            hit = 1'b0;
            for (int c = 0; c < NUM_CHAN; c++) begin
               idx = 8'(c);
               if (wb_adr_i == OFS_THRESH_BASE + 8'(4 * idx)) begin
                  rd[THRESH_W-1:0] = thresh[c];
                  hit = 1'b1;
               end
               if (wb_adr_i == OFS_FREE_BASE + 8'(4 * idx)) begin
                  rd[FREE_W-1:0] = free_cnt[c];
                  hit = 1'b1;
               end
            end
         end
      endcase
      // one-cycle answer; unmapped or partial write gets err
      st_nxt.ack = req && hit && (!wb_we_i || wb_sel_i == 4'hf);
      st_nxt.err = req && !(hit && (!wb_we_i || wb_sel_i == 4'hf));
      st_nxt.dat = (req && !wb_we_i && hit) ? rd : 32'h0000_0000;
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.rx_en <= RX_EN_RST;
         st_r.misc_en <= MISC_EN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flip-flops
   assign wb_dat_o = st_r.dat;
   assign wb_ack_o = st_r.ack;
   assign wb_err_o = st_r.err;
   assign rx_irq_masked = st_r.rx_masked;
   assign misc_irq_masked = st_r.misc_masked;
endmodule : dma_irq_unit

// *** hw/irq_pkg.sv ***
// package: register map, field positions, reset values and widths
package irq_pkg;
   // word offsets (byte addresses) of the register map
   localparam logic [7:0] OFS_RX_RAW = 8'h00;
   localparam logic [7:0] OFS_RX_MASKED = 8'h04;
   localparam logic [7:0] OFS_RX_EN_SET = 8'h08;
   localparam logic [7:0] OFS_RX_EN_CLR = 8'h0c;
   localparam logic [7:0] OFS_MISC_RAW = 8'h10;
   localparam logic [7:0] OFS_MISC_MASKED = 8'h14;
   localparam logic [7:0] OFS_MISC_EN_SET = 8'h18;
   localparam logic [7:0] OFS_MISC_EN_CLR = 8'h1c;
   localparam logic [7:0] OFS_THRESH_BASE = 8'h40;
   localparam logic [7:0] OFS_FREE_BASE = 8'h60;
   // field positions
   localparam int LOW_BUF_LSB = 8;
   localparam int HOST_ERR_BIT = 1;
   localparam int HALF_FULL_BIT = 0;
   // widths
   localparam int THRESH_W = 8;
   localparam int FREE_W = 16;
   localparam int STAT_W = 32;
   // reset values
   localparam logic [15:0] RX_EN_RST = 16'h0000;
   localparam logic [1:0] MISC_EN_RST = 2'h0;
   localparam logic [7:0] THRESH_RST = 8'h00;
   localparam logic [15:0] FREE_RST = 16'h0000;
   // half-range level of a statistics counter
   localparam logic [31:0] STAT_HALF = 32'h8000_0000;
   // wishbone answer latency in cycles
   localparam int ACK_CYCLES = 1;
endpackage : irq_pkg

// *** hw/rx_chan_flow.sv ***
// one receive channel: threshold register, free-buffer counter, low flag
module rx_chan_flow
   import irq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // software writes
   input wire logic thresh_we,
   input wire logic free_we,
   input wire logic [31:0] wdata,
   // frame consumption from the port
   input wire logic frame_done,
   input wire logic [FREE_W-1:0] frame_bufs,
   // state
   output logic [THRESH_W-1:0] thresh,
   output logic [FREE_W-1:0] free_cnt,
   output logic low_flag
);
   typedef struct packed {
      logic [THRESH_W-1:0] thresh;
      logic [FREE_W-1:0] free_cnt;
      logic low_flag;
   } chan_s;

   chan_s st_r;
   chan_s st_nxt;

   // next state: plain threshold write, add on write, subtract per frame
   always_comb begin
      logic [FREE_W-1:0] add_v;
      logic [FREE_W-1:0] sub_v;
      add_v = free_we ? wdata[FREE_W-1:0] : '0;
      sub_v = frame_done ? frame_bufs : '0;
      st_nxt = st_r;
      if (thresh_we) begin
         st_nxt.thresh = wdata[THRESH_W-1:0];
      end
      // wraps modulo 2^16 on overflow
      st_nxt.free_cnt = st_r.free_cnt + add_v - sub_v;
      // low while count below threshold
      st_nxt.low_flag = {8'h00, st_nxt.thresh} > st_nxt.free_cnt;
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '{thresh: THRESH_RST, free_cnt: FREE_RST, low_flag: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign thresh = st_r.thresh;
   assign free_cnt = st_r.free_cnt;
   assign low_flag = st_r.low_flag;
endmodule : rx_chan_flow

// *** hw/stat_half_detect.sv ***
// flags any statistics counter at or above half range
module stat_half_detect
   import irq_pkg::*;
#(
   parameter int NUM_STATS = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // counter values, packed
   input wire logic [NUM_STATS*STAT_W-1:0] stat_values,
   // result
   output logic half_full
);
   typedef struct packed {
      logic half_full;
   } det_s;

   det_s st_r;
   det_s st_nxt;
   logic [NUM_STATS-1:0] hit;

   // per-counter compare
   for (genvar i = 0; i < NUM_STATS; i++) begin : g_cmp
      assign hit[i] = stat_values[i*STAT_W +: STAT_W] >= STAT_HALF;
   end

   always_comb begin
      st_nxt.half_full = |hit;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign half_full = st_r.half_full;
endmodule : stat_half_detect

// *** testbench/dma_irq_unit_properties.sv ***
// concurrent checks on the ports of the irq unit
module dma_irq_unit_chk
   import irq_pkg::*;
#(
   parameter int NUM_CHAN = 8,
   parameter int NUM_STATS = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // events and status
   input wire logic [NUM_CHAN-1:0] rx_chan_packet_flag,
   input wire logic host_error_flag,
   input wire logic [2*NUM_CHAN-1:0] rx_irq_masked,
   input wire logic [1:0] misc_irq_masked
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // bus answer timing and data
   AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
      |=> wb_ack_o ^ wb_err_o) else $error("no single answer one cycle after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("read data outside ack");
   AST_RSVD_ZERO: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
      else $error("reserved bits nonzero");
   AST_ERR_SEL: assert property (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i != 4'hf
      && !wb_ack_o && !wb_err_o |=> wb_err_o) else $error("narrow write not refused");
   // clears and causes of masked status
   AST_RX_CLR: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_RX_EN_CLR
      |-> ##2 (rx_irq_masked & $past(wb_dat_i[15:0], 2)) == 16'h0000)
      else $error("rx enable not cleared");
   AST_MISC_CLR: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_MISC_EN_CLR
      |-> ##2 (misc_irq_masked & $past(wb_dat_i[1:0], 2)) == 2'b00)
      else $error("misc enable not cleared");
   AST_PKT_CAUSE: assert property ((rx_irq_masked[NUM_CHAN-1:0] & ~($past(rx_chan_packet_flag)
      | $past(rx_chan_packet_flag, 2) | $past(rx_chan_packet_flag, 3))) == '0)
      else $error("masked packet bit without flag");
   AST_HOST_CAUSE: assert property (misc_irq_masked[1] |-> $past(host_error_flag)
      || $past(host_error_flag, 2) || $past(host_error_flag, 3)) else $error("host bit no cause");
   AST_RST_CLEAN: assert property ($fell(rst) |-> rx_irq_masked == '0
      && misc_irq_masked == 2'b00) else $error("masked status not clear after reset");
endmodule : dma_irq_unit_chk

bind dma_irq_unit dma_irq_unit_chk #(.NUM_CHAN(NUM_CHAN), .NUM_STATS(NUM_STATS)) chk_i (
   .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .rx_chan_packet_flag(rx_chan_packet_flag),
   .host_error_flag(host_error_flag), .rx_irq_masked(rx_irq_masked),
   .misc_irq_masked(misc_irq_masked));

// *** testbench/tb.sv ***
// self-checking bench for the irq mask and flow-threshold unit
module tb
   import irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] dwr = 32'h0;
   logic [7:0] pkt = 8'h00;
   logic [7:0] fdone = 8'h00;
   logic [127:0] fbufs = '0;
   logic herr = 1'b0;
   logic [127:0] stats = '0;
   logic [31:0] dat_o, rdat;
   logic ack, err, rerr;
   logic [15:0] rxm;
   logic [1:0] mm;
   int err_total = 0;
   int n_compared = 0;
   int cycles = 0;
   dma_irq_unit dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .wb_err_o(err), .rx_chan_packet_flag(pkt), .rx_frame_done(fdone),
      .rx_frame_bufs(fbufs), .host_error_flag(herr), .stat_values(stats),
      .rx_irq_masked(rxm), .misc_irq_masked(mm));
   // clock and hang guard
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         $display("ERROR %0t timeout", $time);
         err_total++;
         results();
      end
   end
   task results;
      if (err_total == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // one classic cycle, held until ack or err
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dwr <= d;
      sel <= s;
      do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
      rdat = dat_o;
      rerr = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask : wr
   task chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      cmp(rdat, e);
   endtask : chk
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         chk(OFS_THRESH_BASE + 8'(4 * c), 32'h0);
         chk(OFS_FREE_BASE + 8'(4 * c), 32'h0);
      end
      wr(OFS_RX_EN_SET, 32'h0105);
      wr(OFS_RX_EN_SET, 32'h0);
      chk(OFS_RX_EN_SET, 32'h0105);
      wr(OFS_RX_EN_CLR, 32'h0001);
      chk(OFS_RX_EN_CLR, 32'h0104);
      pkt <= 8'h05;
      repeat (3) @(posedge clk);
      chk(OFS_RX_RAW, 32'h05);
      chk(OFS_RX_MASKED, 32'h04);
      cmp(32'(rxm), 32'h04);
      wr(OFS_THRESH_BASE + 8'h0c, 32'hffff_ff10);
      chk(OFS_THRESH_BASE + 8'h0c, 32'h10);
      wr(OFS_FREE_BASE + 8'h0c, 32'h0c);
      wr(OFS_FREE_BASE + 8'h0c, 32'h03);
      chk(OFS_FREE_BASE + 8'h0c, 32'h0f);
      wr(OFS_RX_EN_SET, 32'h0800);
      chk(OFS_RX_RAW, 32'h0805);
      chk(OFS_RX_MASKED, 32'h0804);
      wr(OFS_FREE_BASE + 8'h0c, 32'h01);
      repeat (3) @(posedge clk);
      chk(OFS_RX_RAW, 32'h05);
      // frame on channel 3 takes two buffers
      fdone <= 8'h08;
      fbufs[48 +: 16] <= 16'h0002;
      @(posedge clk);
      fdone <= 8'h00;
      repeat (3) @(posedge clk);
      chk(OFS_FREE_BASE + 8'h0c, 32'h0e);
      chk(OFS_RX_RAW, 32'h0805);
      wr(OFS_FREE_BASE + 8'h1c, 32'hffff);
      wr(OFS_FREE_BASE + 8'h1c, 32'h0002);
      chk(OFS_FREE_BASE + 8'h1c, 32'h0001);
      // frame on channel 7 takes two of one buffer: count wraps below zero
      fdone <= 8'h80;
      fbufs[112 +: 16] <= 16'h0002;
      @(posedge clk);
      fdone <= 8'h00;
      chk(OFS_FREE_BASE + 8'h1c, 32'hffff);
      // host error and counter half full
      herr <= 1'b1;
      stats[95:64] <= 32'h7fff_ffff;
      repeat (4) @(posedge clk);
      chk(OFS_MISC_RAW, 32'h2);
      chk(OFS_MISC_MASKED, 32'h0);
      stats[95:64] <= 32'h8000_0000;
      wr(OFS_MISC_EN_SET, 32'h2);
      repeat (4) @(posedge clk);
      chk(OFS_MISC_RAW, 32'h3);
      chk(OFS_MISC_MASKED, 32'h2);
      wr(OFS_MISC_EN_SET, 32'h1);
      repeat (3) @(posedge clk);
      cmp(32'(mm), 32'h3);
      wr(OFS_MISC_EN_CLR, 32'h3);
      chk(OFS_MISC_EN_CLR, 32'h0);
      chk(OFS_MISC_MASKED, 32'h0);
      // refused and ignored accesses
      wr(OFS_RX_RAW, 32'hffff);
      chk(OFS_RX_RAW, 32'h0805);
      bus(1'b1, OFS_THRESH_BASE, 32'h55, 4'h3);
      cmp(32'(rerr), 32'h1);
      chk(OFS_THRESH_BASE, 32'h0);
      bus(1'b0, 8'h20, 32'h0, 4'hf);
      cmp(32'(rerr), 32'h1);
      results();
   end
endmodule : tb
